/* File: verilog/ram_delay_address_generator.sv */
// sample pacing, base pointer and shared address bus schedule for the ram delay line
`timescale 1ns/100ps
module ram_delay_address_generator (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [delay_addr_pkg::WORD_W-1:0] ADC_WORD_I,
  input wire logic [delay_addr_pkg::WORD_W-1:0] RAM_DATA_I,
  input wire logic DOUBLE_MODE_I,
  input wire logic REPEAT_MODE_I,
  input wire logic [delay_addr_pkg::CARDS-1:0] LOAD_STROBE_I,
  input wire logic [delay_addr_pkg::BUS_W-1:0] ADDR_BUS_I,
  output logic SAMPLE_STROBE_O,
  output logic RAM_WE_O,
  output logic [delay_addr_pkg::WORD_W-1:0] RAM_WDATA_O,
  output logic [delay_addr_pkg::BUS_W-1:0] ADDR_BUS_O,
  output logic [delay_addr_pkg::DRIVERS-1:0] ADDR_BUS_OE_O,
  output logic [delay_addr_pkg::CHIP_ADDR_W-1:0] CHIP_ADDR_O,
  output logic [3:0] CHIP_ROW_SEL_O,
  output logic [delay_addr_pkg::CARDS*delay_addr_pkg::WORD_W-1:0] CARD_WORD_O,
  output logic CARD_WORDS_VALID_O,
  output logic LOAD_WINDOW_O
);

  localparam int SYNC_W = delay_addr_pkg::CARDS + 2 + delay_addr_pkg::BUS_W
    + delay_addr_pkg::WORD_W;

  logic rst_meta;
  logic rst_n;

  // reset released through two flip-flops
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pin inputs: three flops, a change counts once stages two and three agree
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] pins;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pins <= '0;
    end else begin
      sync1 <= {LOAD_STROBE_I, DOUBLE_MODE_I, REPEAT_MODE_I, ADDR_BUS_I, RAM_DATA_I};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < SYNC_W; i++) begin
        if (sync2[i] == sync3[i]) begin
          pins[i] <= sync3[i];
        end
      end
    end
  end

  logic [delay_addr_pkg::CARDS-1:0] strobe_lvl;
  logic double_mode;
  logic repeat_mode;
  logic [delay_addr_pkg::BUS_W-1:0] bus_in;
  logic [delay_addr_pkg::WORD_W-1:0] ram_data;

  assign {strobe_lvl, double_mode, repeat_mode, bus_in, ram_data} = pins;

  // sample rate divider: one enable pulse every 20 us
  logic [delay_addr_pkg::SAMPLE_CNT_W-1:0] sample_cnt;
  logic sample_tick;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= '0;
    end else if (sample_cnt == delay_addr_pkg::SAMPLE_LAST) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + 1'b1;
    end
  end

  assign sample_tick = sample_cnt == delay_addr_pkg::SAMPLE_LAST;

  // slot schedule: write, five card reads, one spare, then dead time
  delay_addr_pkg::slot_state_t state;
  delay_addr_pkg::slot_state_t next_state;
  logic [delay_addr_pkg::SLOT_CNT_W-1:0] slot_cnt;
  logic [delay_addr_pkg::SLOT_IDX_W-1:0] slot_idx;
  logic slot_end;

  assign slot_end = slot_cnt == delay_addr_pkg::SLOT_LAST;

  always_comb begin
    next_state = state;
    case (state)
      delay_addr_pkg::ST_IDLE: begin
        if (sample_tick) begin
          next_state = delay_addr_pkg::ST_WRITE;
        end
      end
      delay_addr_pkg::ST_WRITE: begin
        if (slot_end) begin
          next_state = delay_addr_pkg::ST_READ;
        end
      end
      delay_addr_pkg::ST_READ: begin
        if (slot_end && slot_idx == delay_addr_pkg::LAST_READ) begin
          next_state = delay_addr_pkg::ST_SPARE;
        end
      end
      delay_addr_pkg::ST_SPARE: begin
        if (slot_end && slot_idx == delay_addr_pkg::SLOT_IDX_LAST) begin
          next_state = delay_addr_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = delay_addr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= delay_addr_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= '0;
      slot_idx <= '0;
    end else if (state == delay_addr_pkg::ST_IDLE) begin
      slot_cnt <= '0;
      slot_idx <= '0;
    end else if (slot_end) begin
      slot_cnt <= '0;
      slot_idx <= slot_idx + 1'b1;
    end else begin
      slot_cnt <= slot_cnt + 1'b1;
    end
  end

  // base pointer; double mode drops alternate decrements
  delay_addr_pkg::ptr_t base_ptr;
  logic skip_phase;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      skip_phase <= 1'b0;
    end else if (sample_tick) begin
      skip_phase <= double_mode ? ~skip_phase : 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      base_ptr <= delay_addr_pkg::PTR_RESET;
    end else if (sample_tick && !(double_mode && skip_phase)) begin
      if (base_ptr.low == '0) begin
        base_ptr.low <= delay_addr_pkg::LOW_LAST;
        base_ptr.blk <= base_ptr.blk - 1'b1;
      end else begin
        base_ptr.low <= base_ptr.low - 1'b1;
      end
    end
  end

  // card delay registers, loaded from the bus only in dead time
  delay_addr_pkg::dly_t delay_reg [delay_addr_pkg::CARDS];
  logic [delay_addr_pkg::CARDS-1:0] strobe_prev;
  delay_addr_pkg::ptr_t card_addr [delay_addr_pkg::CARDS];

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      strobe_prev <= '0;
    end else begin
      strobe_prev <= strobe_lvl;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < delay_addr_pkg::CARDS; c++) begin
        delay_reg[c] <= delay_addr_pkg::DLY_RESET;
      end
    end else if (state == delay_addr_pkg::ST_IDLE && !sample_tick) begin
      for (int c = 0; c < delay_addr_pkg::CARDS; c++) begin
        if (strobe_lvl[c] && !strobe_prev[c]) begin
          delay_reg[c] <= delay_addr_pkg::dly_t'(bus_in);
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < delay_addr_pkg::CARDS; g++) begin : g_card
      read_address_adder u_adder (
        .base_i(base_ptr),
        .delay_i(delay_reg[g]),
        .addr_o(card_addr[g])
      );
    end
  endgenerate

  // address bus: one driver at a time, full address with no strobing
  delay_addr_pkg::ptr_t bus_addr;
  logic [delay_addr_pkg::DRIVERS-1:0] next_oe;
  logic [delay_addr_pkg::SLOT_IDX_W-1:0] card_sel;

  always_comb begin
    next_oe = '0;
    bus_addr = base_ptr;
    card_sel = slot_idx - delay_addr_pkg::FIRST_READ;
    case (state)
      delay_addr_pkg::ST_WRITE: begin
        next_oe[0] = 1'b1;
      end
      delay_addr_pkg::ST_READ: begin
        next_oe[slot_idx] = 1'b1;
        bus_addr = card_addr[card_sel];
      end
      default: begin
        next_oe = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ADDR_BUS_OE_O <= '0;
      ADDR_BUS_O <= '0;
    end else begin
      ADDR_BUS_OE_O <= next_oe;
      ADDR_BUS_O <= delay_addr_pkg::BUS_W'(bus_addr);
    end
  end

  // chips take the low twelve bits; the block's top two bits pick a chip row
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CHIP_ADDR_O <= '0;
      CHIP_ROW_SEL_O <= '0;
    end else begin
      CHIP_ADDR_O <= {bus_addr.blk[1:0], bus_addr.low};
      CHIP_ROW_SEL_O <= 4'h1 << bus_addr.blk[3:2];
    end
  end

  // write pulse in the write slot, suppressed in repeat mode
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RAM_WE_O <= 1'b0;
      RAM_WDATA_O <= '0;
      SAMPLE_STROBE_O <= 1'b0;
    end else begin
      SAMPLE_STROBE_O <= sample_tick;
      if (sample_tick) begin
        RAM_WDATA_O <= ADC_WORD_I;
      end
      RAM_WE_O <= state == delay_addr_pkg::ST_WRITE && slot_cnt == '0 && !repeat_mode;
    end
  end

  // read data captured at the end of each card's slot
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CARD_WORD_O <= '0;
      CARD_WORDS_VALID_O <= 1'b0;
    end else begin
      CARD_WORDS_VALID_O <= 1'b0;
      if (state == delay_addr_pkg::ST_READ && slot_end) begin
        CARD_WORD_O[card_sel*delay_addr_pkg::WORD_W +: delay_addr_pkg::WORD_W] <= ram_data;
        CARD_WORDS_VALID_O <= slot_idx == delay_addr_pkg::LAST_READ;
      end
    end
  end

  assign LOAD_WINDOW_O = state == delay_addr_pkg::ST_IDLE;

endmodule : ram_delay_address_generator

/* File: verilog/delay_addr_pkg.sv */
// shared types and constants for the ram delay address generator
package delay_addr_pkg;

  // clock and sample timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ = 125_000_000;
  localparam int SAMPLE_HZ = 50_000;
  localparam int SAMPLE_PERIOD_US = 20;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int SLOT_NS = 320;
  localparam int SLOT_CYCLES = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // access schedule
  localparam int CARDS = 5;
  localparam int SLOTS = 7;
  localparam int DRIVERS = CARDS + 1;

  // widths
  localparam int WORD_W = 12;
  localparam int BUS_W = 16;
  localparam int RAM_ADDR_W = 14;
  localparam int CHIP_ADDR_W = 12;
  localparam int SAMPLE_CNT_W = 12;
  localparam int SLOT_CNT_W = 6;
  localparam int SLOT_IDX_W = 3;

  // decimal block mapping
  localparam logic [9:0] LOW_LAST = 10'h3E7;
  localparam logic [10:0] LOW_SPAN = 11'h3E8;
  localparam logic [3:0] BLK_LAST = 4'hF;
  localparam logic [6:0] HUN_WEIGHT = 7'h64;
  localparam logic [3:0] TEN_WEIGHT = 4'hA;

  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYCLES - 1);
  localparam logic [SLOT_IDX_W-1:0] SLOT_IDX_LAST = SLOT_IDX_W'(SLOTS - 1);
  localparam logic [SLOT_IDX_W-1:0] FIRST_READ = 3'h1;
  localparam logic [SLOT_IDX_W-1:0] LAST_READ = SLOT_IDX_W'(CARDS);

  // base pointer and read address: block number, then 0..999 inside the block
  typedef struct packed {
    logic [3:0] blk;
    logic [9:0] low;
  } ptr_t;

  // delay setting: binary block count, then three decimal digits
  typedef struct packed {
    logic [3:0] blk;
    logic [3:0] hun;
    logic [3:0] ten;
    logic [3:0] one;
  } dly_t;

  localparam ptr_t PTR_RESET = '{blk: 4'h0, low: 10'h000};
  localparam dly_t DLY_RESET = '{blk: 4'h0, hun: 4'h0, ten: 4'h0, one: 4'h0};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_SPARE
  } slot_state_t;

endpackage : delay_addr_pkg

/* File: verilog/read_address_adder.sv */
// one output card's read address: base pointer plus decimal-coded delay
`timescale 1ns/100ps
module read_address_adder (
  input wire delay_addr_pkg::ptr_t base_i,
  input wire delay_addr_pkg::dly_t delay_i,
  output delay_addr_pkg::ptr_t addr_o
);

  logic [10:0] dly_bin;
  logic [11:0] low_sum;
  logic [11:0] low_fix;
  logic carry;

  always_comb begin
    // three decimal digits to binary, 0..999
    dly_bin = 11'(delay_i.hun) * 11'(delay_addr_pkg::HUN_WEIGHT)
      + 11'(delay_i.ten) * 11'(delay_addr_pkg::TEN_WEIGHT) + 11'(delay_i.one);
    low_sum = 12'(base_i.low) + 12'(dly_bin);
    carry = low_sum >= 12'(delay_addr_pkg::LOW_SPAN);
    low_fix = carry ? low_sum - 12'(delay_addr_pkg::LOW_SPAN) : low_sum;
    addr_o.low = low_fix[9:0];
    // block sum wraps at the top of memory
    addr_o.blk = 4'(base_i.blk + delay_i.blk + 4'(carry));
  end

endmodule : read_address_adder

/* File: testbench/ram_delay_address_generator_properties.sv */
// concurrent checks on the address generator ports
`timescale 1ns/100ps
module ram_delay_address_generator_properties (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic REPEAT_MODE_I,
  input wire logic SAMPLE_STROBE_O,
  input wire logic RAM_WE_O,
  input wire logic [15:0] ADDR_BUS_O,
  input wire logic [5:0] ADDR_BUS_OE_O,
  input wire logic [11:0] CHIP_ADDR_O,
  input wire logic [3:0] CHIP_ROW_SEL_O,
  input wire logic CARD_WORDS_VALID_O,
  input wire logic LOAD_WINDOW_O
);
  int gap;
  logic seen;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // cycles since the last sample strobe
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      gap <= 0;
      seen <= 1'b0;
    end else if (SAMPLE_STROBE_O) begin
      gap <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  chk_bus_onehot: assert property ($onehot0(ADDR_BUS_OE_O))
    else $error("more than one bus driver");
  chk_we_first: assert property (RAM_WE_O |-> ADDR_BUS_OE_O == 6'h01 &&
    $past(ADDR_BUS_OE_O) == 6'h00) else $error("write pulse outside writer slot start");
  chk_strobe_writer: assert property (SAMPLE_STROBE_O |=> ADDR_BUS_OE_O == 6'h01)
    else $error("writer slot does not follow strobe");
  chk_slot_order: assert property ($changed(ADDR_BUS_OE_O) && ADDR_BUS_OE_O != 6'h00
    |-> ##40 ADDR_BUS_OE_O == ($past(ADDR_BUS_OE_O, 40) << 1)) else $error("slot order or length");
  chk_sample_rate: assert property (SAMPLE_STROBE_O && seen |-> gap == 2499)
    else $error("sample period wrong");
  chk_low_range: assert property (|ADDR_BUS_OE_O |-> ADDR_BUS_O[9:0] <= 10'h3E7 &&
    ADDR_BUS_O[15:14] == 2'h0) else $error("unused block location addressed");
  chk_chip_map: assert property (|ADDR_BUS_OE_O |-> CHIP_ADDR_O == ADDR_BUS_O[11:0] &&
    CHIP_ROW_SEL_O == (4'h1 << ADDR_BUS_O[13:12])) else $error("chip address mismatch");
  chk_valid_after: assert property ($fell(ADDR_BUS_OE_O[5]) |->
    $past(CARD_WORDS_VALID_O)) else $error("card words not flagged");
  chk_repeat_nowrite: assert property (REPEAT_MODE_I && $past(REPEAT_MODE_I, 8)
    |-> !RAM_WE_O) else $error("write pulse in repeat mode");
  chk_window_quiet: assert property (LOAD_WINDOW_O |-> ADDR_BUS_OE_O == 6'h00)
    else $error("load window during bus access");
endmodule : ram_delay_address_generator_properties

bind ram_delay_address_generator ram_delay_address_generator_properties chk (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .REPEAT_MODE_I(REPEAT_MODE_I),
  .SAMPLE_STROBE_O(SAMPLE_STROBE_O), .RAM_WE_O(RAM_WE_O), .ADDR_BUS_O(ADDR_BUS_O),
  .ADDR_BUS_OE_O(ADDR_BUS_OE_O), .CHIP_ADDR_O(CHIP_ADDR_O), .CHIP_ROW_SEL_O(CHIP_ROW_SEL_O),
  .CARD_WORDS_VALID_O(CARD_WORDS_VALID_O), .LOAD_WINDOW_O(LOAD_WINDOW_O));

/* File: testbench/ram_array_model.sv */
// behavioural static ram array on the far side of the address bus
`timescale 1ns/100ps
module ram_array_model (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [11:0] wdata_i,
  input wire logic [11:0] chip_addr_i,
  input wire logic [3:0] row_sel_i,
  input wire logic [5:0] oe_i,
  output logic [11:0] rdata_o
);
  logic [11:0] mem [16384];
  logic [13:0] idx;
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 12'h000;
    rdata_o = 12'h000;
  end
  // whole address taken at once, each chip row spans 0..4095
  always_comb idx = {row_sel_i[3] | row_sel_i[2], row_sel_i[3] | row_sel_i[1], chip_addr_i};
  always @(posedge clk_i) begin
    if (we_i) mem[idx] <= wdata_i;
    // undriven bus gives a toggling pattern, not the last word
    rdata_o <= (|oe_i) ? mem[idx] : ~rdata_o;
  end
endmodule : ram_array_model

/* File: testbench/ram_delay_address_generator_tb_top.sv */
// self-checking bench for the ram delay address generator
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module ram_delay_address_generator_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] adc = 12'hA01;
  logic dbl = 1'b0;
  logic rpt = 1'b0;
  logic [4:0] lds = 5'h00;
  logic [15:0] abus = 16'h0000;
  logic [11:0] rdata, wdata, chip;
  logic strobe, we, valid, window;
  logic [15:0] aout;
  logic [5:0] oe;
  logic [3:0] row;
  logic [59:0] words;
  logic [13:0] ad [6];
  logic [11:0] wd [5];
  logic [15:0] dly [5] = '{16'h0000, 16'h0001, 16'h0999, 16'h1001, 16'hF999};
  int n_fail = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  ram_delay_address_generator uut (.CORE_CLK_I(clk), .RSTN_I(rstn), .ADC_WORD_I(adc),
    .RAM_DATA_I(rdata), .DOUBLE_MODE_I(dbl), .REPEAT_MODE_I(rpt), .LOAD_STROBE_I(lds),
    .ADDR_BUS_I(abus), .SAMPLE_STROBE_O(strobe), .RAM_WE_O(we), .RAM_WDATA_O(wdata),
    .ADDR_BUS_O(aout), .ADDR_BUS_OE_O(oe), .CHIP_ADDR_O(chip), .CHIP_ROW_SEL_O(row),
    .CARD_WORD_O(words), .CARD_WORDS_VALID_O(valid), .LOAD_WINDOW_O(window));
  ram_array_model ram (.clk_i(clk), .we_i(we), .wdata_i(wdata), .chip_addr_i(chip),
    .row_sel_i(row), .oe_i(oe), .rdata_o(rdata));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  function automatic logic [13:0] sum(input logic [13:0] p, input logic [15:0] d);
    logic [10:0] s;
    logic [3:0] b;
    s = p[9:0] + d[11:8] * 11'h064 + d[7:4] * 11'h00A + d[3:0];
    b = p[13:10] + d[15:12];
    if (s > 11'h3E7) begin
      s = s - 11'h3E8;
      b = b + 4'h1;
    end
    return {b, s[9:0]};
  endfunction : sum
  task automatic wait_oe(input logic [5:0] v);
    int n;
    n = 0;
    while (oe !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK("bus enable", v, oe)
  endtask : wait_oe
  // one sample: writer and card addresses, then the card words
  task automatic grab;
    int n;
    for (int k = 0; k < 6; k++) begin
      wait_oe(6'h01 << k);
      ad[k] = aout[13:0];
    end
    n = 0;
    while (valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    `CHK("words valid", 1'b1, valid)
    for (int k = 0; k < 5; k++) wd[k] = words[k*12 +: 12];
  endtask : grab
  task automatic load(input int c, input logic [15:0] v);
    abus = v;
    lds[c] = 1'b1;
    repeat (6) @(negedge clk);
    lds[c] = 1'b0;
    repeat (6) @(negedge clk);
  endtask : load
  task automatic count_we(input int cyc, output logic [7:0] n);
    n = 8'h00;
    repeat (cyc) begin
      @(negedge clk);
      if (we === 1'b1) n++;
    end
  endtask : count_we
  task automatic t_load;
    `CHK("load window", 1'b1, window)
    for (int c = 0; c < 5; c++) load(c, dly[c]);
  endtask : t_load
  task automatic t_sum;
    grab();
    `CHK("write address", 14'h3FE7, ad[0])
    for (int c = 0; c < 5; c++) `CHK("read address", sum(ad[0], dly[c]), ad[c+1])
  endtask : t_sum
  task automatic t_data;
    adc = 12'hA02;
    grab();
    `CHK("write address", 14'h3FE6, ad[0])
    `CHK("zero delay word", 12'hA02, wd[0])
    `CHK("one delay word", 12'hA01, wd[1])
  endtask : t_data
  task automatic t_refuse;
    wait_oe(6'h04);
    load(2, 16'h0123);
    grab();
    `CHK("refused load", sum(ad[0], dly[2]), ad[3])
  endtask : t_refuse
  task automatic t_double;
    logic [13:0] p;
    dbl = 1'b1;
    grab();
    p = ad[0];
    repeat (4) grab();
    `CHK("doubled step", 10'h002, 10'(p[9:0] - ad[0][9:0]))
    dbl = 1'b0;
  endtask : t_double
  task automatic t_repeat;
    logic [7:0] n;
    rpt = 1'b1;
    repeat (10) @(negedge clk);
    count_we(7500, n);
    `CHK("writes held off", 8'h00, n)
    rpt = 1'b0;
    repeat (10) @(negedge clk);
    count_we(2500, n);
    `CHK("writes per sample", 8'h01, n)
  endtask : t_repeat
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_load();
    t_sum();
    t_data();
    t_refuse();
    t_double();
    t_repeat();
    final_report();
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    $display("unexpected watchdog: expected end seen timeout");
    final_report();
  end
endmodule : ram_delay_address_generator_tb_top
